// *** stc_defs.vh ***
/*
  register indices, field positions, reset values and command codes of the
  split timer control block.
  assumes: included by bare name from every design file of the block.
*/
`ifndef STC_DEFS_VH
`define STC_DEFS_VH

// register indices; byte address is four times the index
`define STC_IDX_CLKEN 6'h00
`define STC_IDX_OUTEN 6'h01
`define STC_IDX_OUTVAL 6'h02
`define STC_IDX_SPLIT 6'h03
`define STC_IDX_CMDCLR 6'h04
`define STC_IDX_CMDSET 6'h05
`define STC_IDX_LCNT 6'h20
`define STC_IDX_UCNT 6'h21
`define STC_IDX_LPER 6'h26
`define STC_IDX_UPER 6'h27
`define STC_IDX_CMP_BASE 6'h28
`define STC_IDX_CMP_LAST 6'h2D

// field positions
`define STC_ENABLE_BIT 0
`define STC_DIV_MSB 3
`define STC_DIV_LSB 1
`define STC_SPLIT_BIT 0
`define STC_CMD_MSB 3
`define STC_CMD_LSB 2
`define STC_TGT_MSB 1
`define STC_TGT_LSB 0
`define STC_UPPER_LSB 4

// reset values
`define STC_CLKEN_RST 4'h0
`define STC_OUTEN_RST 6'h00
`define STC_OUTVAL_RST 6'h00
`define STC_TGT_RST 2'h0
`define STC_CNT_RST 8'h00
`define STC_PER_RST 8'hFF
`define STC_CMP_RST 8'h00

// command and target codes
`define STC_CMD_NONE 2'h0
`define STC_CMD_RESTART 2'h2
`define STC_CMD_HARDRST 2'h3
`define STC_TGT_BOTH 2'h3

// prescaler width: largest division is 1024
`define STC_PRE_W 10

`endif

// *** stc_prescaler.v ***
/*
  shared prescaler: one-cycle tick at the peripheral clock divided by the
  selected power of two.
  assumes: divSel and run come from registers on the same clock.
*/
`default_nettype none
`include "stc_defs.vh"

module stc_prescaler (
  // clock and reset
  input wire clk,
  input wire srst,
  // control
  input wire run,
  input wire [2:0] divSel,
  // tick out
  output reg tick
);
  reg [`STC_PRE_W-1:0] preCnt;
  reg [`STC_PRE_W-1:0] mask;

  // division mask per select code
  always @* begin
    case (divSel)
      3'h0: mask = 10'h000;
      3'h1: mask = 10'h001;
      3'h2: mask = 10'h003;
      3'h3: mask = 10'h007;
      3'h4: mask = 10'h00F;
      3'h5: mask = 10'h03F;
      3'h6: mask = 10'h0FF;
      3'h7: mask = 10'h3FF;
      default: mask = 10'h000;
    endcase
  end

  // free count while running, tick when all masked bits are set
  always @(posedge clk) begin
    if (srst || !run) begin
      preCnt <= {`STC_PRE_W{1'b0}};
      tick <= 1'b0;
    end else begin
      preCnt <= preCnt + 10'h001;
      tick <= ((preCnt & mask) == mask);
    end
  end
endmodule
`default_nettype wire

// *** stc_byte_timer.v ***
/*
  one 8-bit down-counting half: counter, period, three compares and the
  compare waveforms.
  assumes: tick, commands and write strobes are one-cycle pulses on clk.
*/
`default_nettype none
`include "stc_defs.vh"

module stc_byte_timer (
  // clock and reset
  input wire clk,
  input wire srst,
  // timing and commands
  input wire tick,
  input wire restart,
  input wire hardRst,
  // register writes
  input wire wrCnt,
  input wire wrPer,
  input wire [2:0] wrCmp,
  input wire [7:0] wrData,
  // state
  output reg [7:0] cnt,
  output reg [7:0] per,
  output reg [23:0] cmp,
  output reg [2:0] wave
);
  integer i;
  integer j;

  // counter: a register write beats count, clear and reload
  always @(posedge clk) begin
    if (srst) begin
      cnt <= `STC_CNT_RST;
    end else if (wrCnt) begin
      cnt <= wrData;
    end else if (hardRst || restart) begin
      cnt <= `STC_CNT_RST;
    end else if (tick) begin
      cnt <= (cnt == 8'h00) ? per : cnt - 8'h01;
    end
  end

  // period and compare values
  always @(posedge clk) begin
    if (srst || hardRst) begin
      per <= `STC_PER_RST;
      cmp <= {3{`STC_CMP_RST}};
    end else begin
      if (wrPer) begin
        per <= wrData;
      end
      for (i = 0; i < 3; i = i + 1) begin
        if (wrCmp[i]) begin
          cmp[i*8 +: 8] <= wrData;
        end
      end
    end
  end

  // single-slope compare waveforms
  always @(posedge clk) begin
    if (srst || hardRst || restart) begin
      wave <= 3'h0;
    end else begin
      for (j = 0; j < 3; j = j + 1) begin
        wave[j] <= (cmp[j*8 +: 8] > cnt);
      end
    end
  end
endmodule
`default_nettype wire

// *** stc_split_timer.v ***
/*
  split timer control: classic wishbone register slave, prescaler, command
  decode, two 8-bit halves and the six waveform outputs.
  register map, byte address four times the index:
  0x00 divider select and enable, 0x04 output enables, 0x08 output values,
  0x0C split select, 0x10 target clear, 0x14 target set and command,
  0x80 and 0x84 counters, 0x98 and 0x9C periods, 0xA0 to 0xB4 compares;
  the counter, period and compare words answer only while split is set.
  assumes: a classic wishbone master on clk; waveform outputs and override
  enables feed a port multiplexer outside.
  limits: the compare wave is a plain level, cmp above cnt, and a hard
  reset touches only the two halves, not the control registers.
  command bits are never stored; they act as one-cycle pulses.
*/
// Our own choice: the Wishbone interface to the registers.
`default_nettype none
`include "stc_defs.vh"

// Function
// - divider select gives 1 to 1024 tick
// - enable bit runs timer only while split bit is set, resets to stopped
// - upper enable replaces port on upper output
// - lower enable replaces port on lower output
// - stopped: upper value bits drive upper outputs
// - stopped: lower value bits drive lower outputs
// - split bit makes two 8-bit timers
// - clear register clears bits written one
// - set register sets bits written one
// - command field always reads zero
// - restart, hard reset unless enabled
// - target code three selects both halves
// - counter writes beat count and reload
module stc_split_timer (
  // clock and reset
  input wire clk,
  input wire srst,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // waveform outputs and port override enables
  output reg [2:0] waveOutLower,
  output reg [2:0] waveOutUpper,
  output reg [2:0] overrideLower,
  output reg [2:0] overrideUpper
);
  // control registers
  reg [3:0] clkEnable;
  reg [5:0] outEnable;
  reg [5:0] outValue;
  reg dualSelect;
  reg [1:0] targetSelect;

  // command pulses
  reg restartPulse;
  reg hardRstPulse;

  // bus decode and write strobes
  wire [5:0] idx;
  wire busReq;
  wire wrStb;
  wire rdStb;
  wire splitWr;
  wire wrCntLower;
  wire wrCntUpper;
  wire wrPerLower;
  wire wrPerUpper;
  wire wrCmdClr;
  wire wrCmdSet;
  wire cmdBoth;
  wire hardRstOk;
  wire timerOn;
  wire tick;
  wire [1:0] cmdIn;
  reg [1:0] next_target;
  wire cmpHit;
  wire [2:0] cmpNum;
  wire cmpUpper;
  wire [2:0] wrCmpLower;
  wire [2:0] wrCmpUpper;

  // state of the two halves
  wire [7:0] cntLower;
  wire [7:0] cntUpper;
  wire [7:0] perLower;
  wire [7:0] perUpper;
  wire [23:0] cmpLower;
  wire [23:0] cmpUpper8;
  wire [2:0] waveLower;
  wire [2:0] waveUpper;
  reg [7:0] rdByte;
  reg [2:0] next_waveLower;
  reg [2:0] next_waveUpper;

  // bus decode; a write lands on the edge that raises ack
  assign idx = adr_i[7:2];
  assign busReq = cyc_i && stb_i && !ack_o;
  assign wrStb = busReq && we_i && sel_i[0];
  assign rdStb = busReq && !we_i;
  assign cmdIn = dat_i[`STC_CMD_MSB:`STC_CMD_LSB];

  // halves count only while enabled and split
  assign timerOn = clkEnable[`STC_ENABLE_BIT] && dualSelect;

  // split-map and command strobes; the split map answers only while split
  assign splitWr = wrStb && dualSelect;
  assign wrCntLower = splitWr && idx == `STC_IDX_LCNT;
  assign wrCntUpper = splitWr && idx == `STC_IDX_UCNT;
  assign wrPerLower = splitWr && idx == `STC_IDX_LPER;
  assign wrPerUpper = splitWr && idx == `STC_IDX_UPER;
  assign wrCmdClr = wrStb && idx == `STC_IDX_CMDCLR;
  assign wrCmdSet = wrStb && idx == `STC_IDX_CMDSET;
  // a command acts only with both halves selected after this write
  assign cmdBoth = wrCmdSet && next_target == `STC_TGT_BOTH;
  // hard reset is refused while the enable bit is set
  assign hardRstOk = !clkEnable[`STC_ENABLE_BIT];

  // compare register decode, lower at even and upper at odd index
  assign cmpHit = dualSelect && (idx >= `STC_IDX_CMP_BASE) &&
    (idx <= `STC_IDX_CMP_LAST);
  assign cmpNum = idx[3:1] - 3'h4;
  assign cmpUpper = idx[0];
  assign wrCmpLower = (wrStb && cmpHit && !cmpUpper) ?
    (3'h1 << cmpNum) : 3'h0;
  assign wrCmpUpper = (wrStb && cmpHit && cmpUpper) ?
    (3'h1 << cmpNum) : 3'h0;

  // target select after this cycle's clear or set write
  // only one of the two registers is written per cycle, so they never meet
  always @* begin
    next_target = targetSelect;
    if (wrCmdClr) begin
      next_target = targetSelect & ~dat_i[`STC_TGT_MSB:`STC_TGT_LSB];
    end else if (wrCmdSet) begin
      next_target = targetSelect | dat_i[`STC_TGT_MSB:`STC_TGT_LSB];
    end
  end

  // shared prescaler for both halves
  stc_prescaler prescaler (
    .clk(clk),
    .srst(srst),
    .run(timerOn),
    .divSel(clkEnable[`STC_DIV_MSB:`STC_DIV_LSB]),
    .tick(tick)
  );

  // lower half
  stc_byte_timer lowerHalf (
    .clk(clk),
    .srst(srst),
    .tick(tick),
    .restart(restartPulse),
    .hardRst(hardRstPulse),
    .wrCnt(wrCntLower),
    .wrPer(wrPerLower),
    .wrCmp(wrCmpLower),
    .wrData(dat_i[7:0]),
    .cnt(cntLower),
    .per(perLower),
    .cmp(cmpLower),
    .wave(waveLower)
  );

  // upper half
  stc_byte_timer upperHalf (
    .clk(clk),
    .srst(srst),
    .tick(tick),
    .restart(restartPulse),
    .hardRst(hardRstPulse),
    .wrCnt(wrCntUpper),
    .wrPer(wrPerUpper),
    .wrCmp(wrCmpUpper),
    .wrData(dat_i[7:0]),
    .cnt(cntUpper),
    .per(perUpper),
    .cmp(cmpUpper8),
    .wave(waveUpper)
  );

  // control register writes
  always @(posedge clk) begin
    if (srst) begin
      clkEnable <= `STC_CLKEN_RST;
      outEnable <= `STC_OUTEN_RST;
      outValue <= `STC_OUTVAL_RST;
      dualSelect <= 1'b0;
      targetSelect <= `STC_TGT_RST;
    end else begin
      targetSelect <= next_target;
      if (wrStb) begin
        case (idx)
          `STC_IDX_CLKEN: begin
            clkEnable <= dat_i[3:0];
          end
          `STC_IDX_OUTEN: begin
            outEnable <= {dat_i[6:4], dat_i[2:0]};
          end
          `STC_IDX_OUTVAL: begin
            outValue <= {dat_i[6:4], dat_i[2:0]};
          end
          `STC_IDX_SPLIT: begin
            dualSelect <= dat_i[`STC_SPLIT_BIT];
          end
          default: begin
            clkEnable <= clkEnable;
          end
        endcase
      end
    end
  end

  // command decode from the set register; the clear side only clears
  always @(posedge clk) begin
    if (srst) begin
      restartPulse <= 1'b0;
      hardRstPulse <= 1'b0;
    end else begin
      restartPulse <= 1'b0;
      hardRstPulse <= 1'b0;
      if (cmdBoth) begin
        case (cmdIn)
          `STC_CMD_RESTART: begin
            restartPulse <= 1'b1;
          end
          `STC_CMD_HARDRST: begin
            hardRstPulse <= hardRstOk;
          end
          default: begin
            restartPulse <= 1'b0;
          end
        endcase
      end
    end
  end

  // read multiplexer; split-map registers read zero unless split
  always @* begin
    rdByte = 8'h00;
    case (idx)
      `STC_IDX_CLKEN: rdByte = {4'h0, clkEnable};
      `STC_IDX_OUTEN: rdByte = {1'b0, outEnable[5:3], 1'b0, outEnable[2:0]};
      `STC_IDX_OUTVAL: rdByte = {1'b0, outValue[5:3], 1'b0, outValue[2:0]};
      `STC_IDX_SPLIT: rdByte = {7'h00, dualSelect};
      `STC_IDX_CMDCLR: rdByte = {6'h00, targetSelect};
      `STC_IDX_CMDSET: rdByte = {6'h00, targetSelect};
      `STC_IDX_LCNT: rdByte = dualSelect ? cntLower : 8'h00;
      `STC_IDX_UCNT: rdByte = dualSelect ? cntUpper : 8'h00;
      `STC_IDX_LPER: rdByte = dualSelect ? perLower : 8'h00;
      `STC_IDX_UPER: rdByte = dualSelect ? perUpper : 8'h00;
      default: begin
        if (cmpHit && cmpUpper) begin
          rdByte = cmpUpper8[cmpNum*8 +: 8];
        end else if (cmpHit) begin
          rdByte = cmpLower[cmpNum*8 +: 8];
        end
      end
    endcase
  end

  // single-cycle acknowledge, read data captured with it
  always @(posedge clk) begin
    if (srst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= busReq;
      if (rdStb) begin
        dat_o <= {24'h000000, rdByte};
      end
    end
  end

  // output levels: compare waves while running, value bits while stopped
  always @* begin
    if (timerOn) begin
      next_waveLower = waveLower;
      next_waveUpper = waveUpper;
    end else begin
      next_waveLower = outValue[2:0];
      next_waveUpper = outValue[5:3];
    end
  end

  // registered waveform outputs and port override enables
  always @(posedge clk) begin
    if (srst) begin
      waveOutLower <= 3'h0;
      waveOutUpper <= 3'h0;
      overrideLower <= 3'h0;
      overrideUpper <= 3'h0;
    end else begin
      overrideLower <= outEnable[2:0];
      overrideUpper <= outEnable[5:3];
      waveOutLower <= next_waveLower;
      waveOutUpper <= next_waveUpper;
    end
  end
endmodule
`default_nettype wire

// *** stc_split_timer_properties.sv ***
/*
  port checker of the split timer control block.
  assumes: bound to stc_split_timer; one clock, srst high.
*/
`default_nettype none
module stc_split_props (
  // clock and reset
  input wire clk,
  input wire srst,
  // register bus
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  // waveform side
  input wire [2:0] waveOutLower,
  input wire [2:0] waveOutUpper,
  input wire [2:0] overrideLower,
  input wire [2:0] overrideUpper
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // request decode
  wire take = cyc_i && stb_i && !ack_o;
  wire wr = take && we_i && sel_i[0];
  wire rd = take && !we_i;
  wire [5:0] idx = adr_i[7:2];
  wire [2:0] dLow = dat_i[2:0];
  wire [2:0] dHigh = dat_i[6:4];
  reg [3:0] ctrl;
  reg [1:0] tgt;
  // mirrors of the control byte and command target
  always @(posedge clk) begin
    if (srst) begin
      ctrl <= 4'h0;
      tgt <= 2'h0;
    end else if (wr && idx == 6'h00) begin
      ctrl <= dat_i[3:0];
    end else if (wr && idx == 6'h04) begin
      tgt <= tgt & ~dat_i[1:0];
    end else if (wr && idx == 6'h05) begin
      tgt <= tgt | dat_i[1:0];
    end
  end
  a_ack_answer: assert property (take |=> ack_o)
    else $error("request not answered");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(take))
    else $error("ack without request");
  a_data_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ctrl_readback: assert property (
    rd && idx == 6'h00 |=> dat_o[3:0] == ctrl)
    else $error("control readback wrong");
  a_target_readback: assert property (
    rd && idx == 6'h04 |=> dat_o[1:0] == tgt)
    else $error("target readback wrong");
  a_cmd_zero: assert property (
    rd && (idx == 6'h04 || idx == 6'h05) |=> dat_o[3:2] == 2'h0)
    else $error("command field not zero");
  a_unmapped_zero: assert property (
    rd && idx > 6'h05 && idx < 6'h20 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_override_follow: assert property (wr && idx == 6'h01 |->
    ##2 {overrideUpper, overrideLower} == {$past(dHigh, 2), $past(dLow, 2)})
    else $error("override not from enables");
  a_value_drive: assert property (wr && idx == 6'h02 && !ctrl[0] |->
    ##2 {waveOutUpper, waveOutLower} == {$past(dHigh, 2), $past(dLow, 2)})
    else $error("stopped output not from values");
endmodule
bind stc_split_timer stc_split_props chk (.clk(clk), .srst(srst),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .waveOutLower(waveOutLower), .waveOutUpper(waveOutUpper),
  .overrideLower(overrideLower), .overrideUpper(overrideUpper));
`default_nettype wire

// *** stc_split_timer_test.sv ***
/*
  self-checking bench of the split timer control block.
  assumes: classic wishbone slave, one clock at 200 MHz.
*/
`default_nettype none
module stc_split_timer_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  wire [31:0] rdat;
  wire ack;
  wire [2:0] waveLo, waveHi, ovrLo, ovrHi;
  int failCount = 0;
  int samplesChecked = 0;
  stc_split_timer uut (.clk(clk), .srst(srst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .waveOutLower(waveLo), .waveOutUpper(waveHi),
    .overrideLower(ovrLo), .overrideUpper(ovrHi));
  // 5 ns clock
  always #2.5 clk = ~clk;
  // counts, verdict and end of run
  task automatic giveVerdict;
    $display("mismatches %0d comparisons %0d", failCount, samplesChecked);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // compare one value
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic bus cycle, held until ack is sampled
  task automatic access(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      failCount++;
      $display("[FAIL] %0t no bus answer", $time);
      giveVerdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    access(1'b0, a, 8'h00, q);
    check(q, e);
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) rdChk(8'(4 * i), 32'h0);
    rdChk(8'h18, 32'h0);
    rdChk(8'h98, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 8'(c * 2));
      rdChk(8'h00, 32'(c * 2));
    end
    wr(8'h04, 8'h61);
    wr(8'h08, 8'h52);
    @(posedge clk);
    check(32'({ovrHi, ovrLo}), 32'h31);
    check(32'({waveHi, waveLo}), 32'h2A);
    wr(8'h0C, 8'h01);
    rdChk(8'h0C, 32'h1);
    rdChk(8'h98, 32'hFF);
    wr(8'h14, 8'h03);
    rdChk(8'h10, 32'h3);
    wr(8'h10, 8'h01);
    rdChk(8'h14, 32'h2);
    wr(8'h98, 8'h10);
    wr(8'h14, 8'h0D);
    rdChk(8'h98, 32'hFF);
    rdChk(8'h14, 32'h3);
    // hard reset refused while enabled
    wr(8'h98, 8'h10);
    wr(8'h00, 8'h01);
    wr(8'h14, 8'h0C);
    rdChk(8'h98, 32'h10);
    wr(8'h00, 8'h00);
    // restart clears both counters
    wr(8'h80, 8'h40);
    wr(8'h84, 8'h40);
    wr(8'h14, 8'h08);
    rdChk(8'h80, 32'h0);
    rdChk(8'h84, 32'h0);
    // three ticks at divide 64, then stop mid-period
    wr(8'h00, 8'h0B);
    repeat (3 * 64 + 30) @(posedge clk);
    wr(8'h00, 8'h0A);
    rdChk(8'h80, 32'h0E);
    rdChk(8'h84, 32'hFD);
    // restart with no target selected leaves the counters alone
    wr(8'h10, 8'h03);
    wr(8'h14, 8'h08);
    rdChk(8'h80, 32'h0E);
    rdChk(8'h10, 32'h0);
    // compare words, then running outputs follow the compare waves
    wr(8'hA0, 8'hFF);
    rdChk(8'hA0, 32'hFF);
    rdChk(8'hA4, 32'h0);
    wr(8'h00, 8'h0F);
    @(posedge clk);
    check(32'({waveHi, waveLo}), 32'h01);
    // counter write beats the divide-1 count in the same cycle
    wr(8'h00, 8'h01);
    wr(8'h80, 8'h40);
    rdChk(8'h80, 32'h3E);
    // stopped again: value bits drive the outputs
    wr(8'h00, 8'h00);
    @(posedge clk);
    check(32'({waveHi, waveLo}), 32'h2A);
    giveVerdict();
  end
endmodule
`default_nettype wire
